// file: rtl/spcb_pkg.sv
// package: offsets, field positions and reset values of the port two control bank
package spcb_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 8'h86;
    localparam logic [ADDR_W-1:0] OFS_DEFAULT_TAG = 8'h88;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_C = 8'h8A;
    localparam logic [ADDR_W-1:0] OFS_INGRESS_RATE_LOW = 8'h8C;
    // control_b fields
    localparam int CB_VLAN_FILTER = 14;
    localparam int CB_NON_PORT_DEFAULT_VLAN_ID_DISCARD = 13;
    localparam int CB_FORCE_FLOW = 12;
    localparam int CB_BACK_PRESSURE = 11;
    localparam int CB_TX_ENABLE = 10;
    localparam int CB_RX_ENABLE = 9;
    localparam int CB_LEARN_DISABLE = 8;
    localparam int CB_MIRROR_DEST = 7;
    localparam int CB_RX_SNIFF = 6;
    localparam int CB_TX_SNIFF = 5;
    localparam int CB_PRIO_CEILING = 3;
    localparam int CB_MEMBER_HI = 2;
    localparam int CB_MEMBER_LO = 0;
    localparam logic [15:0] CONTROL_B_RESET = 16'h0607;
    // default tag fields
    localparam int DT_PRIO_HI = 15;
    localparam int DT_PRIO_LO = 13;
    localparam int DT_CFI = 12;
    localparam int DT_VID_HI = 11;
    localparam int DT_VID_LO = 0;
    localparam logic [15:0] DEFAULT_TAG_RESET = 16'h0001;
    // control_c fields; bits 15..5 read as zero
    localparam int CC_MODE_HI = 3;
    localparam int CC_MODE_LO = 2;
    localparam int CC_COUNT_IFG = 1;
    localparam int CC_COUNT_PREAMBLE = 0;
    localparam logic [15:0] CONTROL_C_WMASK = 16'h001F;
    localparam logic [15:0] CONTROL_C_RESET = 16'h0000;
    // ingress rate low fields
    localparam int IR_PRIO1_HI = 14;
    localparam int IR_PRIO1_LO = 8;
    localparam int IR_PRIO0_HI = 6;
    localparam int IR_PRIO0_LO = 0;
    localparam logic [15:0] INGRESS_RATE_RESET = 16'h0000;
    // port membership bit positions
    localparam int MEMBER_HOST = 2;
    localparam int MEMBER_SELF = 1;
    localparam int MEMBER_FIRST = 0;
    // rate overhead per frame
    localparam logic [11:0] IFG_BYTES = 12'h00C;
    localparam logic [11:0] PREAMBLE_BYTES = 12'h008;
    localparam logic [6:0] RATE_NO_LIMIT = 7'h00;
    typedef enum logic [1:0]
    {
        SPCB_LIMIT_ALL = 2'h0,
        SPCB_LIMIT_BMF = 2'h1,
        SPCB_LIMIT_BM = 2'h2,
        SPCB_LIMIT_B = 2'h3
    } spcb_limit_mode_t;
endpackage

// file: rtl/spcb_rate_lut.sv
// lookup from seven-bit rate code to bandwidth in kbit/s
module spcb_rate_lut
    import spcb_pkg::*;
#(
    parameter logic [19:0] FULL_RATE_KBPS = 20'h186A0,
    parameter logic [19:0] STEP_KBPS = 20'h003E8
)
(
    input wire logic [6:0] rateCode,
    output logic [19:0] rateKbps,
    output logic rateLimited
);
    logic [26:0] product;
    always_comb
    begin
        product = 27'(rateCode) * 27'(STEP_KBPS);
        // R19 zero code no limit
        rateLimited = (rateCode != RATE_NO_LIMIT);
        if (!rateLimited)
        begin
            rateKbps = FULL_RATE_KBPS;
        end
        else if (product > 27'(FULL_RATE_KBPS))
        begin
            rateKbps = FULL_RATE_KBPS;
        end
        else
        begin
            rateKbps = product[19:0];
        end
    end
endmodule

// file: rtl/spcb_bank.sv
// port two control bank: registers and per-frame decisions they steer
// Operation
// R1: filter ingress not in VLAN membership
// R2: drop frames whose VID differs from default
// R3: force flow control over negotiated result
// R4: enable half-duplex back pressure
// R5: transmit enable gates all transmission
// R6: receive enable gates all reception
// R7: learning disable stops source learning
// R8: mirror destination sends monitored frames
// R9: receive sniff marks and mirrors received
// R10: transmit sniff marks and mirrors transmitted
// R11: priority ceiling clamps to user priority
// R12: membership bits select reachable ports
// R13: default tag fields, VID resets 001
// R14: default VID for untagged and null
// R15: limit mode picks counted frame kinds
// R16: inter-frame gap adds twelve bytes
// R17: preamble adds eight bytes
// R18: seven-bit limits for priority 0, 1
// R19: zero rate code means no limit
// R20: inserted tag carries ingress default VID
// R21: rate codes map through separate table
module spcb_bank
    import spcb_pkg::*;
#(
    parameter logic [19:0] FULL_RATE_KBPS = 20'h186A0,
    parameter logic [19:0] STEP_KBPS = 20'h003E8
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [1:0] regByteEn,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regRdValid,
    input wire logic negotiatedFlow,
    output logic flowControlOn,
    output logic backPressureOn,
    output logic [2:0] portMembership,
    input wire logic rxValid,
    input wire logic rxTagged,
    input wire logic [11:0] rxVid,
    input wire logic [2:0] rxPrio,
    input wire logic [2:0] rxVlanMembers,
    input wire logic rxBroadcast,
    input wire logic rxMulticast,
    input wire logic rxFlooded,
    input wire logic [10:0] rxLength,
    output logic rxDecValid,
    output logic rxDrop,
    output logic rxLearn,
    output logic rxMonitor,
    output logic [11:0] rxVidOut,
    output logic [2:0] rxPrioOut,
    output logic rxRateCounted,
    output logic [6:0] rxRateCode,
    output logic [19:0] rxRateKbps,
    output logic rxRateLimited,
    output logic [11:0] rxRateBytes,
    input wire logic txValid,
    input wire logic txMonitored,
    input wire logic [10:0] txLength,
    output logic txDecValid,
    output logic txSend,
    output logic txMirror,
    output logic [11:0] txRateBytes
);
    logic [15:0] controlB_q;
    logic [15:0] defaultTag_q;
    logic [15:0] controlC_q;
    logic [15:0] ingressRate_q;
    logic [15:0] byteMask;
    logic hitB;
    logic hitTag;
    logic hitC;
    logic hitRate;
    logic [11:0] port_default_vlan_id;
    logic [2:0] userPrio;
    logic [11:0] effVid;
    logic [2:0] effPrio;
    logic dropNow;
    logic countedNow;
    logic [6:0] codeNow;
    logic [11:0] overhead;
    logic [19:0] lutKbps;
    logic lutLimited;
    spcb_limit_mode_t limitMode;

    assign byteMask = {{8{regByteEn[1]}}, {8{regByteEn[0]}}};
    assign hitB = (regAddr == OFS_CONTROL_B);
    assign hitTag = (regAddr == OFS_DEFAULT_TAG);
    assign hitC = (regAddr == OFS_CONTROL_C);
    assign hitRate = (regAddr == OFS_INGRESS_RATE_LOW);
    // R13 default tag fields
    assign port_default_vlan_id = defaultTag_q[DT_VID_HI:DT_VID_LO];
    assign userPrio = defaultTag_q[DT_PRIO_HI:DT_PRIO_LO];
    assign limitMode = spcb_limit_mode_t'(controlC_q[CC_MODE_HI:CC_MODE_LO]);

    // register writes with byte lanes
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            controlB_q <= CONTROL_B_RESET;
            defaultTag_q <= DEFAULT_TAG_RESET;
            controlC_q <= CONTROL_C_RESET;
            ingressRate_q <= INGRESS_RATE_RESET;
        end
        else if (regWrite)
        begin
            if (hitB)
            begin
                controlB_q <= (controlB_q & ~byteMask) | (regWdata & byteMask);
            end
            if (hitTag)
            begin
                defaultTag_q <= (defaultTag_q & ~byteMask) | (regWdata & byteMask);
            end
            if (hitC)
            begin
                controlC_q <= (controlC_q & ~(byteMask & CONTROL_C_WMASK))
                    | (regWdata & byteMask & CONTROL_C_WMASK);
            end
            if (hitRate)
            begin
                ingressRate_q <= (ingressRate_q & ~byteMask) | (regWdata & byteMask);
            end
        end
    end

    // read answer one cycle later; unmapped reads return zero
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            regRdata <= 16'h0000;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead;
            if (regRead)
            begin
                regRdata <= hitB ? controlB_q : hitTag ? defaultTag_q :
                    hitC ? controlC_q : hitRate ? ingressRate_q : 16'h0000;
            end
        end
    end

    // port level controls
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            flowControlOn <= 1'b0;
            backPressureOn <= 1'b0;
            portMembership <= CONTROL_B_RESET[CB_MEMBER_HI:CB_MEMBER_LO];
        end
        else
        begin
            // R3 force flow control
            flowControlOn <= controlB_q[CB_FORCE_FLOW] | negotiatedFlow;
            // R4 back pressure enable
            backPressureOn <= controlB_q[CB_BACK_PRESSURE];
            // R12 membership out
            portMembership <= controlB_q[CB_MEMBER_HI:CB_MEMBER_LO];
        end
    end

    always_comb
    begin
        // R14 default VID substitution
        effVid = (!rxTagged || rxVid == 12'h000) ? port_default_vlan_id : rxVid;
        // R11 priority ceiling
        effPrio = (controlB_q[CB_PRIO_CEILING] && rxPrio > userPrio) ? userPrio : rxPrio;
        // R6 receive gate
        dropNow = !controlB_q[CB_RX_ENABLE];
        // R1 ingress VLAN filter
        if (controlB_q[CB_VLAN_FILTER] && !rxVlanMembers[MEMBER_SELF])
        begin
            dropNow = 1'b1;
        end
        // R2 non-default VID discard
        if (controlB_q[CB_NON_PORT_DEFAULT_VLAN_ID_DISCARD] && effVid != port_default_vlan_id)
        begin
            dropNow = 1'b1;
        end
        // R15 limit mode select
        case (limitMode)
            SPCB_LIMIT_ALL: countedNow = 1'b1;
            SPCB_LIMIT_BMF: countedNow = rxBroadcast | rxMulticast | rxFlooded;
            SPCB_LIMIT_BM: countedNow = rxBroadcast | rxMulticast;
            SPCB_LIMIT_B: countedNow = rxBroadcast;
            default: countedNow = 1'b1;
        endcase
        // R18 per-priority limit field
        case (effPrio)
            3'h0: codeNow = ingressRate_q[IR_PRIO0_HI:IR_PRIO0_LO];
            3'h1: codeNow = ingressRate_q[IR_PRIO1_HI:IR_PRIO1_LO];
            default: codeNow = RATE_NO_LIMIT;
        endcase
        // R16 gap bytes, R17 preamble bytes
        overhead = (controlC_q[CC_COUNT_IFG] ? IFG_BYTES : 12'h000)
            + (controlC_q[CC_COUNT_PREAMBLE] ? PREAMBLE_BYTES : 12'h000);
    end

    // R21 separate rate table
    spcb_rate_lut #(
        .FULL_RATE_KBPS(FULL_RATE_KBPS),
        .STEP_KBPS(STEP_KBPS)
    ) rateTable (
        .rateCode(codeNow),
        .rateKbps(lutKbps),
        .rateLimited(lutLimited)
    );

    // ingress decision, registered one cycle after rxValid
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rxDecValid <= 1'b0;
            rxDrop <= 1'b0;
            rxLearn <= 1'b0;
            rxMonitor <= 1'b0;
            rxVidOut <= 12'h000;
            rxPrioOut <= 3'h0;
            rxRateCounted <= 1'b0;
            rxRateCode <= RATE_NO_LIMIT;
            rxRateKbps <= 20'h00000;
            rxRateLimited <= 1'b0;
            rxRateBytes <= 12'h000;
        end
        else
        begin
            rxDecValid <= rxValid;
            if (rxValid)
            begin
                rxDrop <= dropNow;
                // R7 learning disable
                rxLearn <= !dropNow && !controlB_q[CB_LEARN_DISABLE];
                // R9 receive sniff
                rxMonitor <= !dropNow && controlB_q[CB_RX_SNIFF];
                // R20 tag VID for later insertion
                rxVidOut <= effVid;
                rxPrioOut <= effPrio;
                rxRateCounted <= countedNow;
                rxRateCode <= codeNow;
                // R19 unlimited on zero
                rxRateKbps <= lutKbps;
                rxRateLimited <= countedNow && lutLimited;
                rxRateBytes <= 12'(rxLength) + overhead;
            end
        end
    end

    // egress decision, registered one cycle after txValid
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            txDecValid <= 1'b0;
            txSend <= 1'b0;
            txMirror <= 1'b0;
            txRateBytes <= 12'h000;
        end
        else
        begin
            txDecValid <= txValid;
            if (txValid)
            begin
                // R5 transmit gate, R8 mirror destination
                txSend <= controlB_q[CB_TX_ENABLE]
                    && (!txMonitored || controlB_q[CB_MIRROR_DEST]);
                // R10 transmit sniff
                txMirror <= controlB_q[CB_TX_ENABLE] && controlB_q[CB_TX_SNIFF];
                txRateBytes <= 12'(txLength) + overhead;
            end
        end
    end

    // checks
    rx_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
        rxValid && !controlB_q[CB_RX_ENABLE] |=> rxDecValid && rxDrop)
        else $error("reception not blocked");
    vlan_filter_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
        rxValid && controlB_q[CB_VLAN_FILTER] && !rxVlanMembers[MEMBER_SELF] |=> rxDrop)
        else $error("non-member frame kept");
    port_default_vlan_id_discard_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
        rxValid && controlB_q[CB_NON_PORT_DEFAULT_VLAN_ID_DISCARD] && rxTagged && rxVid != 12'h000
        && rxVid != port_default_vlan_id |=> rxDrop)
        else $error("foreign VID kept");
    null_vid_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
        rxValid && (!rxTagged || rxVid == 12'h000) |=> rxVidOut == $past(port_default_vlan_id))
        else $error("default VID not applied");
    prio_ceiling_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
        rxValid && controlB_q[CB_PRIO_CEILING] && rxPrio > userPrio
        |=> rxPrioOut == $past(userPrio))
        else $error("priority not clamped");
    learn_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
        rxValid && controlB_q[CB_LEARN_DISABLE] |=> !rxLearn)
        else $error("learning while disabled");
    rate_bytes_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R16
        rxValid && controlC_q[CC_COUNT_IFG] && controlC_q[CC_COUNT_PREAMBLE]
        |=> rxRateBytes == 12'($past(rxLength)) + 12'h014)
        else $error("overhead bytes wrong");
    tx_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
        txValid && !controlB_q[CB_TX_ENABLE] |=> txDecValid && !txSend && !txMirror)
        else $error("transmission not blocked");
    flow_force_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
        controlB_q[CB_FORCE_FLOW] ##1 controlB_q[CB_FORCE_FLOW] |-> flowControlOn)
        else $error("flow control not forced");
    vid_reset_a: assert property (@(posedge ref_clk) // R13
        !reset_n |=> defaultTag_q == DEFAULT_TAG_RESET)
        else $error("default tag reset wrong");
    zero_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
        rxValid && codeNow == RATE_NO_LIMIT |=> !rxRateLimited && rxRateKbps == FULL_RATE_KBPS)
        else $error("zero code limited");
    sniff_rx_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
        rxValid && !dropNow && controlB_q[CB_RX_SNIFF] |=> rxMonitor)
        else $error("received frame not monitored");
    mirror_dest_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
        txValid && txMonitored && !controlB_q[CB_MIRROR_DEST] |=> txDecValid && !txSend)
        else $error("monitored frame sent by normal port");
    tx_sniff_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
        txValid && controlB_q[CB_TX_ENABLE] && controlB_q[CB_TX_SNIFF] |=> txMirror)
        else $error("transmitted frame not mirrored");
    back_pressure_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
        backPressureOn == $past(controlB_q[CB_BACK_PRESSURE]))
        else $error("back pressure not following control");
    membership_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
        portMembership == $past(controlB_q[CB_MEMBER_HI:CB_MEMBER_LO]))
        else $error("membership not following control");
    limit_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
        rxValid && limitMode == SPCB_LIMIT_B && !rxBroadcast |=> !rxRateCounted)
        else $error("non-broadcast counted in broadcast mode");
    cov_drop_c: cover property (@(posedge ref_clk) disable iff (!reset_n) rxDecValid && rxDrop);
    cov_limit_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        rxDecValid && rxRateLimited);
    cov_mirror_c: cover property (@(posedge ref_clk) disable iff (!reset_n) txDecValid && txMirror);
    cov_read_c: cover property (@(posedge ref_clk) disable iff (!reset_n) regRdValid ##1 regRdValid);
endmodule

// file: bench/switch_port_control_bank_tb.sv
// self-checking testbench for the port two control bank
module switch_port_control_bank_tb
    import spcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, regWrite, regRead, negotiatedFlow, rxValid, rxTagged;
    logic rxBroadcast, rxMulticast, rxFlooded, txValid, txMonitored;
    logic [ADDR_W-1:0] regAddr;
    logic [1:0] regByteEn;
    logic [15:0] regWdata, regRdata;
    logic [11:0] rxVid, rxVidOut, rxRateBytes, txRateBytes;
    logic [2:0] rxPrio, rxVlanMembers, rxPrioOut, portMembership;
    logic [10:0] rxLength, txLength;
    logic [6:0] rxRateCode;
    logic [19:0] rxRateKbps;
    logic regRdValid, flowControlOn, backPressureOn, rxDecValid, rxDrop, rxLearn;
    logic rxMonitor, rxRateCounted, rxRateLimited, txDecValid, txSend, txMirror;
    int numErrors = 0;
    int numChecks = 0;

    spcb_bank #(.FULL_RATE_KBPS(20'h186A0), .STEP_KBPS(20'h003E8)) spcb_bank_i
    (
        .ref_clk, .reset_n, .regAddr, .regWrite, .regRead, .regByteEn, .regWdata,
        .regRdata, .regRdValid, .negotiatedFlow, .flowControlOn, .backPressureOn,
        .portMembership, .rxValid, .rxTagged, .rxVid, .rxPrio, .rxVlanMembers,
        .rxBroadcast, .rxMulticast, .rxFlooded, .rxLength, .rxDecValid, .rxDrop,
        .rxLearn, .rxMonitor, .rxVidOut, .rxPrioOut, .rxRateCounted, .rxRateCode,
        .rxRateKbps, .rxRateLimited, .rxRateBytes, .txValid, .txMonitored, .txLength,
        .txDecValid, .txSend, .txMirror, .txRateBytes
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic giveVerdict;
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regByteEn <= be;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    // read answers exactly one cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(20'(regRdValid), 20'h1);
        chk(20'(regRdata), 20'(exp));
    endtask

    // one rx and one tx descriptor in the same cycle; kind is broadcast, multicast, flooded
    task automatic frame(input logic t, input logic [11:0] v, input logic [2:0] p,
        input logic [2:0] mem, input logic [2:0] kind, input logic [10:0] len);
        @(posedge ref_clk);
        rxTagged <= t;
        rxVid <= v;
        rxPrio <= p;
        rxVlanMembers <= mem;
        {rxBroadcast, rxMulticast, rxFlooded} <= kind;
        rxLength <= len;
        txLength <= len;
        rxValid <= 1'b1;
        txValid <= 1'b1;
        @(posedge ref_clk);
        rxValid <= 1'b0;
        txValid <= 1'b0;
        #1;
        chk(20'({rxDecValid, txDecValid}), 20'h3);
    endtask

    task automatic scnReset;
        chk(20'(portMembership), 20'h7);
        rd(OFS_CONTROL_B, 16'h0607);
        rd(OFS_DEFAULT_TAG, 16'h0001);
        rd(OFS_CONTROL_C, 16'h0000);
        rd(OFS_INGRESS_RATE_LOW, 16'h0000);
    endtask

    task automatic scnRegs;
        wr(OFS_CONTROL_B, 2'h1, 16'hFFFF);
        rd(OFS_CONTROL_B, 16'h06FF);
        wr(OFS_CONTROL_C, 2'h3, 16'hFFFF);
        rd(OFS_CONTROL_C, 16'h001F);
        wr(OFS_INGRESS_RATE_LOW, 2'h3, 16'hFFFF);
        rd(OFS_INGRESS_RATE_LOW, 16'hFFFF);
        // unmapped place swallows writes and reads as zero
        wr(8'h8E, 2'h3, 16'h1234);
        rd(8'h8E, 16'h0000);
    endtask

    task automatic scnFlow;
        wr(OFS_CONTROL_B, 2'h3, 16'h1805);
        settle(2);
        chk(20'({flowControlOn, backPressureOn, portMembership}), 20'h1D);
        wr(OFS_CONTROL_B, 2'h3, 16'h0000);
        negotiatedFlow <= 1'b1;
        settle(2);
        chk(20'({flowControlOn, backPressureOn}), 20'h2);
        @(posedge ref_clk);
        negotiatedFlow <= 1'b0;
        settle(2);
        chk(20'(flowControlOn), 20'h0);
    endtask

    task automatic scnRx;
        wr(OFS_DEFAULT_TAG, 2'h3, 16'h4005);
        wr(OFS_CONTROL_B, 2'h3, 16'h0648);
        frame(1'b0, 12'h000, 3'h5, 3'h2, 3'h0, 11'h040);
        chk(20'(rxVidOut), 20'h005);
        chk(20'(rxPrioOut), 20'h2);
        chk(20'({rxDrop, rxLearn, rxMonitor}), 20'h3);
        frame(1'b1, 12'h000, 3'h1, 3'h2, 3'h0, 11'h040);
        chk(20'({rxVidOut, rxPrioOut}), 20'h0029);
        wr(OFS_CONTROL_B, 2'h3, 16'h6748);
        frame(1'b1, 12'h005, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({rxDrop, rxLearn}), 20'h0);
        frame(1'b1, 12'h123, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'(rxDrop), 20'h1);
        frame(1'b1, 12'h005, 3'h0, 3'h5, 3'h0, 11'h040);
        chk(20'(rxDrop), 20'h1);
        wr(OFS_CONTROL_B, 2'h3, 16'h0448);
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({rxDrop, rxMonitor}), 20'h2);
    endtask

    task automatic scnMode;
        wr(OFS_CONTROL_B, 2'h3, 16'h0607);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_CONTROL_C, 2'h3, {12'h000, 2'(m), 2'h0});
            for (int k = 0; k < 4; k++)
            begin
                frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h4 >> k, 11'h040);
                chk(20'(rxRateCounted), 20'(k + m <= 3));
            end
        end
    endtask

    task automatic scnRate;
        wr(OFS_INGRESS_RATE_LOW, 2'h3, 16'h0500);
        for (int ov = 0; ov < 4; ov++)
        begin
            wr(OFS_CONTROL_C, 2'h3, {14'h0000, 2'(ov)});
            frame(1'b0, 12'h000, 3'h1, 3'h2, 3'h0, 11'h100);
            chk(20'(rxRateBytes), 20'(12'h100 + (ov[1] ? 12 : 0) + (ov[0] ? 8 : 0)));
            chk(20'(txRateBytes), 20'(12'h100 + (ov[1] ? 12 : 0) + (ov[0] ? 8 : 0)));
        end
        chk(20'({rxRateLimited, rxRateCode}), 20'h85);
        chk(rxRateKbps, 20'h01388);
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h100);
        chk(20'({rxRateLimited, rxRateCode}), 20'h00);
        chk(rxRateKbps, 20'h186A0);
        frame(1'b0, 12'h000, 3'h2, 3'h2, 3'h0, 11'h100);
        chk(20'(rxRateCode), 20'h00);
    endtask

    task automatic scnTx;
        wr(OFS_CONTROL_B, 2'h3, 16'h06A7);
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({txSend, txMirror}), 20'h3);
        wr(OFS_CONTROL_B, 2'h3, 16'h0687);
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({txSend, txMirror}), 20'h2);
        wr(OFS_CONTROL_B, 2'h3, 16'h02A7);
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({txSend, txMirror}), 20'h0);
        // normal port holds back monitored copies, still sends plain frames
        wr(OFS_CONTROL_B, 2'h3, 16'h0627);
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({txSend, txMirror}), 20'h1);
        @(posedge ref_clk);
        txMonitored <= 1'b0;
        frame(1'b0, 12'h000, 3'h0, 3'h2, 3'h0, 11'h040);
        chk(20'({txSend, txMirror}), 20'h3);
    endtask

    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        numErrors++;
        giveVerdict();
    end

    initial
    begin
        {reset_n, regWrite, regRead, negotiatedFlow, rxValid, rxTagged} = '0;
        {rxBroadcast, rxMulticast, rxFlooded, txValid, txMonitored} = 5'h01;
        {regAddr, regByteEn, regWdata, rxVid, rxPrio, rxVlanMembers} = '0;
        {rxLength, txLength} = '0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle(0);
        scnReset();
        scnRegs();
        scnFlow();
        scnRx();
        scnMode();
        scnRate();
        scnTx();
        giveVerdict();
    end
endmodule
